/* rtl/pcc_map.vh */
// Register map, field positions, reset values and timing figures
// Assumes inclusion by the phy configuration block and its helpers
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCC_IDX_CONFIG_THREE 6'h1E
`define PCC_IDX_SOFT_CONTROL 6'h1F
`define PCC_IDX_TEST_CHANNEL 6'h25
`define PCC_IDX_XOVER_TIMER 6'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCC_B_FFD_EN 11
`define PCC_B_ROBUST_EN 9
`define PCC_B_QUICK_EN 8
`define PCC_B_INT_OE 7
`define PCC_B_FORCE_INT 6
`define PCC_B_CT_FAILED 2
`define PCC_B_CT_COMPLETE 1
`define PCC_B_CT_LAUNCH 0
`define PCC_B_FULL_RESET 15
`define PCC_B_RESTART 14
`define PCC_B_TCH_ALL 7
`define PCC_F_TCH_SEL 6:5
`define PCC_F_TCH_FIELD 7:5
`define PCC_F_XT_RSVD 15:4
`define PCC_F_XT_TIMER 3:0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCC_RST_TCH_HIGH 8'h04
`define PCC_RST_TCH_SEL 3'h0
`define PCC_RST_TCH_LOW 5'h00
`define PCC_RST_XT_RSVD 12'h141
`define PCC_RST_XT_TIMER 4'hF

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define PCC_RESP_OKAY 2'h0
`define PCC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCC_CLK_MHZ 200
`define PCC_XOVER_STEP_MS 32
`define PCC_XOVER_NORM_MS 64
`define PCC_XOVER_QUICK_MS 8
`define PCC_CYC_PER_MS (`PCC_CLK_MHZ * 1000)
`define PCC_LFSR_SEED 8'hA5
`define PCC_LFSR_TAPS 8'hB8
`define PCC_TMR_W 28

`endif

/* rtl/pcc_period_timer.v */
// Down counter that pulses once per programmed period
// Assumes period is at least one; restart reloads it
`include "pcc_map.vh"

module pcc_period_timer (
  input wire sys_clk,
  input wire srst,
  input wire restart,
  input wire [`PCC_TMR_W-1:0] period,
  output reg expire_q
);
  reg [`PCC_TMR_W-1:0] cnt_q;

  always @(posedge sys_clk) begin
    if (srst || restart) begin
      cnt_q <= period;
      expire_q <= 1'b0;
    end else if (cnt_q <= {{(`PCC_TMR_W-1){1'b0}}, 1'b1}) begin
      cnt_q <= period;
      expire_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - {{(`PCC_TMR_W-1){1'b0}}, 1'b1};
      expire_q <= 1'b0;
    end
  end
endmodule // pcc_period_timer

/* rtl/pcc_regs.v */
// Configuration and control registers of a tri-speed copper transceiver
// Assumes an AXI4-Lite master on sys_clk, core status inputs on sys_clk,
// and an open-drain, active-low shared interrupt / power-down pin
`include "pcc_map.vh"

module pcc_regs #(
  parameter XOVER_STEP_CYC = `PCC_XOVER_STEP_MS * `PCC_CYC_PER_MS,
  parameter XOVER_NORM_CYC = `PCC_XOVER_NORM_MS * `PCC_CYC_PER_MS,
  parameter XOVER_QUICK_CYC = `PCC_XOVER_QUICK_MS * `PCC_CYC_PER_MS
) (
  input wire sys_clk,
  input wire srst,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core status
  input wire link_up,
  input wire local_an_enable,
  input wire local_forced_100,
  input wire partner_forced_100,
  input wire std_full_duplex,
  input wire irq_event,
  input wire cable_test_finish,
  input wire cable_test_fail_in,
  // Shared pin, active low
  input wire irq_pd_pin_n_in,
  output reg irq_pd_pin_n_out,
  output reg irq_pd_pin_n_oe,
  // Core control
  output reg link_full_duplex,
  output reg mdix_swap,
  output reg cable_test_start,
  output reg core_full_reset,
  output reg core_restart,
  output reg powerdown_req,
  output reg [3:0] test_channel_en
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg forced_full_duplex_enable_q;
  reg robust_crossover_enable_q;
  reg quick_crossover_enable_q;
  reg int_oe_q;
  reg force_int_q;
  reg cable_test_launch_q;
  reg cable_test_complete_q;
  reg cable_test_failed_q;
  reg full_soft_reset_q;
  reg soft_restart_keep_regs_q;
  reg [2:0] test_channel_select_q;
  reg [11:0] xt_rsvd_q;
  reg [3:0] robust_crossover_timer_q;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  reg aw_hold_q;
  reg [5:0] aw_idx_q;
  reg w_hold_q;
  reg [15:0] wdata_q;
  reg [1:0] wstrb_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [5:0] ar_idx = s_axi_araddr[7:2];

  wire wr_config_three = wr_go && (aw_idx_q == `PCC_IDX_CONFIG_THREE);
  wire wr_ctrl = wr_go && (aw_idx_q == `PCC_IDX_SOFT_CONTROL);
  wire wr_tch = wr_go && (aw_idx_q == `PCC_IDX_TEST_CHANNEL);
  wire wr_xt = wr_go && (aw_idx_q == `PCC_IDX_XOVER_TIMER);
  wire wr_hit = wr_config_three || wr_ctrl || wr_tch || wr_xt;

  // Merged write data honouring byte strobes
  reg [15:0] cur_d;
  reg [15:0] new_d;

  // Registers fall back to defaults on bus reset or full soft reset
  wire reg_rst = srst || full_soft_reset_q;
  // Device-side state also restarts on soft restart
  wire core_rst = reg_rst || soft_restart_keep_regs_q;

  // ----------------------------------------------------------------
  // Read view of each register
  // ----------------------------------------------------------------
  wire [15:0] config_three_view = {4'h0, forced_full_duplex_enable_q, 1'b0,
    robust_crossover_enable_q, quick_crossover_enable_q, int_oe_q,
    force_int_q, 3'h0, cable_test_failed_q, cable_test_complete_q,
    cable_test_launch_q};
  wire [15:0] ctrl_view = {full_soft_reset_q, soft_restart_keep_regs_q,
    14'h0000};
  wire [15:0] tch_view = {`PCC_RST_TCH_HIGH, test_channel_select_q,
    `PCC_RST_TCH_LOW};
  wire [15:0] xt_view = {xt_rsvd_q, robust_crossover_timer_q};

  always @* begin
    case (aw_idx_q)
      `PCC_IDX_CONFIG_THREE: cur_d = config_three_view;
      `PCC_IDX_SOFT_CONTROL: cur_d = ctrl_view;
      `PCC_IDX_TEST_CHANNEL: cur_d = tch_view;
      `PCC_IDX_XOVER_TIMER: cur_d = xt_view;
      default: cur_d = 16'h0000;
    endcase
    new_d[7:0] = wstrb_q[0] ? wdata_q[7:0] : cur_d[7:0];
    new_d[15:8] = wstrb_q[1] ? wdata_q[15:8] : cur_d[15:8];
  end

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCC_RESP_OKAY;
      aw_hold_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_hold_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[15:0];
        wstrb_q <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PCC_RESP_OKAY;
      case (ar_idx)
        `PCC_IDX_CONFIG_THREE: s_axi_rdata <= {16'h0000, config_three_view};
        `PCC_IDX_SOFT_CONTROL: s_axi_rdata <= {16'h0000, ctrl_view};
        `PCC_IDX_TEST_CHANNEL: s_axi_rdata <= {16'h0000, tch_view};
        `PCC_IDX_XOVER_TIMER: s_axi_rdata <= {16'h0000, xt_view};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PCC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration register three
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reg_rst) begin
      forced_full_duplex_enable_q <= 1'b0;
      robust_crossover_enable_q <= 1'b0;
      quick_crossover_enable_q <= 1'b0;
      int_oe_q <= 1'b0;
      force_int_q <= 1'b0;
      cable_test_launch_q <= 1'b0;
    end else if (wr_config_three) begin
      forced_full_duplex_enable_q <= new_d[`PCC_B_FFD_EN];
      robust_crossover_enable_q <= new_d[`PCC_B_ROBUST_EN];
      quick_crossover_enable_q <= new_d[`PCC_B_QUICK_EN];
      int_oe_q <= new_d[`PCC_B_INT_OE];
      force_int_q <= new_d[`PCC_B_FORCE_INT];
      cable_test_launch_q <= new_d[`PCC_B_CT_LAUNCH];
    end
  end

  // Launch pulse on every write of one to the start bit
  wire ct_launch = wr_config_three && new_d[`PCC_B_CT_LAUNCH];

  // Completion wins over a launch in the same cycle
  always @(posedge sys_clk) begin
    if (reg_rst) begin
      cable_test_complete_q <= 1'b1;
      cable_test_failed_q <= 1'b0;
    end else if (cable_test_finish) begin
      cable_test_complete_q <= 1'b1;
      cable_test_failed_q <= cable_test_fail_in;
    end else if (ct_launch) begin
      cable_test_complete_q <= 1'b0;
      cable_test_failed_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Soft control, test channel and crossover timer registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reg_rst) begin
      full_soft_reset_q <= 1'b0;
      soft_restart_keep_regs_q <= 1'b0;
    end else begin
      full_soft_reset_q <= wr_ctrl && new_d[`PCC_B_FULL_RESET];
      soft_restart_keep_regs_q <= wr_ctrl && new_d[`PCC_B_RESTART];
    end
  end

  always @(posedge sys_clk) begin
    if (reg_rst) begin
      test_channel_select_q <= `PCC_RST_TCH_SEL;
      xt_rsvd_q <= `PCC_RST_XT_RSVD;
      robust_crossover_timer_q <= `PCC_RST_XT_TIMER;
    end else begin
      if (wr_tch)
        test_channel_select_q <= new_d[`PCC_F_TCH_FIELD];
      if (wr_xt) begin
        xt_rsvd_q <= new_d[`PCC_F_XT_RSVD];
        robust_crossover_timer_q <= new_d[`PCC_F_XT_TIMER];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  wire pin_level;

  pcc_sync2 #(
    .W(1)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in(irq_pd_pin_n_in),
    .rst_val(1'b1),
    .sync_q(pin_level)
  );

  always @(posedge sys_clk) begin
    if (core_rst) begin
      irq_pd_pin_n_out <= 1'b0;
      irq_pd_pin_n_oe <= 1'b0;
      powerdown_req <= 1'b0;
    end else begin
      irq_pd_pin_n_out <= 1'b0;
      // Open drain: pull low only while interrupting
      irq_pd_pin_n_oe <= int_oe_q && (force_int_q || irq_event);
      powerdown_req <= !int_oe_q && !pin_level;
    end
  end

  // ----------------------------------------------------------------
  // Duplex, test channels and control pulses
  // ----------------------------------------------------------------
  wire ffd_case = forced_full_duplex_enable_q && partner_forced_100 &&
    (local_an_enable || local_forced_100);
  reg [3:0] tch_onehot;

  always @* begin
    case (test_channel_select_q[1:0])
      2'h0: tch_onehot = 4'h1;
      2'h1: tch_onehot = 4'h2;
      2'h2: tch_onehot = 4'h4;
      2'h3: tch_onehot = 4'h8;
      default: tch_onehot = 4'h0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (core_rst) begin
      link_full_duplex <= 1'b0;
      test_channel_en <= 4'h1;
      cable_test_start <= 1'b0;
    end else begin
      link_full_duplex <= ffd_case ? 1'b1 : std_full_duplex;
      test_channel_en <= test_channel_select_q[2] ? 4'hF : tch_onehot;
      cable_test_start <= ct_launch;
    end
  end

  // Reset pulses would never leave if core_rst dropped them, so run them on srst
  always @(posedge sys_clk) begin
    if (srst) begin
      core_full_reset <= 1'b0;
      core_restart <= 1'b0;
    end else begin
      core_full_reset <= full_soft_reset_q;
      core_restart <= soft_restart_keep_regs_q;
    end
  end

  // ----------------------------------------------------------------
  // Crossover resolver
  // ----------------------------------------------------------------
  localparam [`PCC_TMR_W-1:0] STEP_CYC = XOVER_STEP_CYC[`PCC_TMR_W-1:0];
  localparam [`PCC_TMR_W-1:0] NORM_CYC = XOVER_NORM_CYC[`PCC_TMR_W-1:0];
  localparam [`PCC_TMR_W-1:0] QUICK_CYC = XOVER_QUICK_CYC[`PCC_TMR_W-1:0];

  wire both_forced = !local_an_enable && local_forced_100 && partner_forced_100;
  wire quick_case = quick_crossover_enable_q && both_forced;
  wire [4:0] robust_steps = {1'b0, robust_crossover_timer_q} + 5'h01;
  wire [`PCC_TMR_W+4:0] robust_full = STEP_CYC * robust_steps;
  reg [`PCC_TMR_W-1:0] xover_period;
  reg [7:0] lfsr_q;
  wire xover_tick;

  // Timer setting applies only in robust mode
  always @* begin
    if (quick_case)
      xover_period = QUICK_CYC;
    else if (robust_crossover_enable_q)
      xover_period = robust_full[`PCC_TMR_W-1:0];
    else
      xover_period = NORM_CYC;
  end

  pcc_period_timer u_xover_tmr (
    .sys_clk(sys_clk),
    .srst(core_rst),
    .restart(link_up),
    .period(xover_period),
    .expire_q(xover_tick)
  );

  // Random skip of a swap breaks lock-step with a partner doing the same
  always @(posedge sys_clk) begin
    if (core_rst) begin
      lfsr_q <= `PCC_LFSR_SEED;
      mdix_swap <= 1'b0;
    end else begin
      lfsr_q <= {1'b0, lfsr_q[7:1]} ^ (lfsr_q[0] ? `PCC_LFSR_TAPS : 8'h00);
      if (xover_tick && !link_up) begin
        if (!robust_crossover_enable_q || lfsr_q[0])
          mdix_swap <= !mdix_swap;
      end
    end
  end

endmodule // pcc_regs

/* rtl/pcc_sync2.v */
// Two flip-flop synchroniser for levels from outside the clock domain
// Assumes the input is a slow level, not a pulse
module pcc_sync2 #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire srst,
  input wire [W-1:0] async_in,
  input wire [W-1:0] rst_val,
  output reg [W-1:0] sync_q
);
  reg [W-1:0] meta_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= rst_val;
      sync_q <= rst_val;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // pcc_sync2

/* verification/pcc_link_model.sv */
// Cable-test partner and shared open-drain pin seen from the far side
// Assumes one clock; the pin has a pull-up
module pcc_link_model #(
  parameter int TEST_LEN = 12
) (
  input wire sys_clk,
  input wire cable_test_start,
  input wire fail_sel,
  input wire ext_pd_low,
  input wire pin_oe,
  input wire pin_out,
  output logic cable_test_finish,
  output logic cable_test_fail_in,
  output wire pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial cable_test_finish = 1'b0;
  initial cable_test_fail_in = 1'b0;
  // Any party pulling low wins, else the pull-up
  assign pin_n = ((pin_oe && !pin_out) || ext_pd_low) ? 1'b0 : 1'b1;
  // Outcome is only meaningful with the finish pulse
  always @(posedge sys_clk) begin
    cable_test_finish <= (cnt == 1);
    cable_test_fail_in <= (cnt == 1) ? fail_sel : ~cable_test_fail_in;
    if (cable_test_start) begin
      cnt <= TEST_LEN;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // pcc_link_model

/* verification/pcc_regs_bench.sv */
// Self-checking bench for the phy configuration register block
// Assumes the design, the link model and the bound checker compiled first
`include "pcc_map.vh"
module pcc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0] ix;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [1:0] rs;
  } pcc_row_t;
  logic sys_clk = 1'b0, srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic link_up = 1'b1, an_en = 1'b1, loc_100 = 1'b0, par_100 = 1'b0, std_fd = 1'b0;
  logic irq_event = 1'b0, fail_sel = 1'b0, ext_pd_low = 1'b0, swap_q = 1'b0;
  logic [1:0] resp;
  logic [15:0] rv;
  wire awready, wready, bvalid, arready, rvalid, ct_start, ct_fin, ct_fail, pin_n;
  wire pin_out, pin_oe, full_dup, swap, full_rst, restart, pd_req;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] chan_en;
  int num_errors = 0, n_checks = 0, cyc = 0, tg = 0, t0 = 0, n_rs = 0, n_fr = 0;
  pcc_row_t rows [0:11] = '{
    '{`PCC_IDX_CONFIG_THREE, 16'h0BF8, 16'h0BC2, `PCC_RESP_OKAY},
    '{`PCC_IDX_CONFIG_THREE, 16'h0000, 16'h0002, `PCC_RESP_OKAY},
    '{`PCC_IDX_SOFT_CONTROL, 16'h3FFF, 16'h0000, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'hFFFF, 16'h04E0, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'h0000, 16'h0400, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'h0020, 16'h0420, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'h0040, 16'h0440, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'h0060, 16'h0460, `PCC_RESP_OKAY},
    '{`PCC_IDX_TEST_CHANNEL, 16'h00A0, 16'h04A0, `PCC_RESP_OKAY},
    '{`PCC_IDX_XOVER_TIMER, 16'hABC5, 16'hABC5, `PCC_RESP_OKAY},
    '{`PCC_IDX_XOVER_TIMER, 16'h0000, 16'h0000, `PCC_RESP_OKAY},
    '{6'h20, 16'h1234, 16'h0000, `PCC_RESP_SLVERR}};

  pcc_regs #(.XOVER_STEP_CYC(20), .XOVER_NORM_CYC(40), .XOVER_QUICK_CYC(5)) uut (
    .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_up(link_up),
    .local_an_enable(an_en), .local_forced_100(loc_100), .partner_forced_100(par_100),
    .std_full_duplex(std_fd), .irq_event(irq_event), .cable_test_finish(ct_fin),
    .cable_test_fail_in(ct_fail), .irq_pd_pin_n_in(pin_n), .irq_pd_pin_n_out(pin_out),
    .irq_pd_pin_n_oe(pin_oe), .link_full_duplex(full_dup), .mdix_swap(swap),
    .cable_test_start(ct_start), .core_full_reset(full_rst), .core_restart(restart),
    .powerdown_req(pd_req), .test_channel_en(chan_en));
  pcc_link_model #(.TEST_LEN(12)) u_link (.sys_clk(sys_clk), .cable_test_start(ct_start),
    .fail_sel(fail_sel), .ext_pd_low(ext_pd_low), .pin_oe(pin_oe), .pin_out(pin_out),
    .cable_test_finish(ct_fin), .cable_test_fail_in(ct_fail), .pin_n(pin_n));

  // ----------------------------------------------------------------
  // Clock, monitors, timeout
  // ----------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    swap_q <= swap;
    tg += (swap !== swap_q);
    n_rs += (restart === 1'b1);
    n_fr += (full_rst === 1'b1);
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [15:0] d);
    @(posedge sys_clk);
    awaddr <= {ix, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] ix);
    @(posedge sys_clk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata[15:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic defaults;
    logic [5:0] ix [4];
    logic [15:0] dv [4];
    ix = '{`PCC_IDX_CONFIG_THREE, `PCC_IDX_SOFT_CONTROL, `PCC_IDX_TEST_CHANNEL,
      `PCC_IDX_XOVER_TIMER};
    dv = '{16'h0002, 16'h0000, 16'h0400, 16'h141F};
    for (int k = 0; k < 4; k++) begin
      rd(ix[k]);
      chk(rv, dv[k]);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    defaults();
    foreach (rows[i]) begin
      wr(rows[i].ix, rows[i].wd);
      chk(resp, rows[i].rs);
      rd(rows[i].ix);
      chk(rv, rows[i].rd);
      chk(resp, rows[i].rs);
      if (rows[i].ix == `PCC_IDX_TEST_CHANNEL)
        chk(chan_en, rows[i].wd[7] ? 4'hF : 4'h1 << rows[i].wd[6:5]);
    end
    for (int f = 0; f < 2; f++) begin
      fail_sel <= f[0];
      wr(`PCC_IDX_CONFIG_THREE, 16'h0001);
      rd(`PCC_IDX_CONFIG_THREE);
      chk(rv, 16'h0001);
      repeat (20) @(posedge sys_clk);
      rd(`PCC_IDX_CONFIG_THREE);
      chk(rv, {13'h0, f[0], 2'h3});
    end
    wr(`PCC_IDX_CONFIG_THREE, 16'h00C0);
    repeat (3) @(posedge sys_clk);
    chk({pin_oe, pin_n}, 2'b10);
    wr(`PCC_IDX_CONFIG_THREE, 16'h0080);
    repeat (3) @(posedge sys_clk);
    chk(pin_oe, 1'b0);
    irq_event <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(pin_oe, 1'b1);
    wr(`PCC_IDX_CONFIG_THREE, 16'h0000);
    ext_pd_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({pin_oe, pd_req}, 2'b01);
    ext_pd_low <= 1'b0;
    irq_event <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(pd_req, 1'b0);
    std_fd <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(full_dup, 1'b1);
    std_fd <= 1'b0;
    par_100 <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      wr(`PCC_IDX_CONFIG_THREE, {4'h0, f[0], 11'h000});
      repeat (3) @(posedge sys_clk);
      chk(full_dup, f[0]);
    end
    link_up <= 1'b0;
    an_en <= 1'b0;
    loc_100 <= 1'b1;
    std_fd <= 1'b1;
    wr(`PCC_IDX_CONFIG_THREE, 16'h0100);
    t0 = tg;
    repeat (100) @(posedge sys_clk);
    chk(tg - t0 >= 12, 1'b1);
    wr(`PCC_IDX_CONFIG_THREE, 16'h0000);
    t0 = tg;
    repeat (100) @(posedge sys_clk);
    chk(tg - t0 <= 3, 1'b1);
    wr(`PCC_IDX_CONFIG_THREE, 16'h0200);
    t0 = tg;
    repeat (200) @(posedge sys_clk);
    chk(tg - t0 >= 1 && tg - t0 <= 10, 1'b1);
    link_up <= 1'b1;
    wr(`PCC_IDX_XOVER_TIMER, 16'h0005);
    t0 = n_rs;
    wr(`PCC_IDX_SOFT_CONTROL, 16'h4000);
    repeat (4) @(posedge sys_clk);
    chk(n_rs - t0, 1);
    rd(`PCC_IDX_XOVER_TIMER);
    chk(rv, 16'h0005);
    rd(`PCC_IDX_SOFT_CONTROL);
    chk(rv, 16'h0000);
    t0 = n_fr;
    wr(`PCC_IDX_SOFT_CONTROL, 16'h8000);
    repeat (4) @(posedge sys_clk);
    chk(n_fr - t0, 1);
    defaults();
    wr(`PCC_IDX_TEST_CHANNEL, 16'h0060);
    srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    defaults();
    chk(chan_en, 4'h1);
    test_done();
  end
endmodule // pcc_regs_bench

/* verification/pcc_regs_checker.sv */
// Concurrent checks on the ports of the phy configuration register block
// Assumes one clock sys_clk and a synchronous active-high srst
module pcc_regs_checker (
  input wire sys_clk,
  input wire srst,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire local_an_enable,
  input wire local_forced_100,
  input wire partner_forced_100,
  input wire std_full_duplex,
  input wire irq_pd_pin_n_out,
  input wire irq_pd_pin_n_oe,
  input wire link_full_duplex,
  input wire cable_test_start,
  input wire core_full_reset,
  input wire core_restart,
  input wire [3:0] test_channel_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_std_duplex;
    !(partner_forced_100 && (local_an_enable || local_forced_100)) && !core_restart &&
      !core_full_reset |=> core_restart || core_full_reset ||
      link_full_duplex == $past(std_full_duplex);
  endproperty
  a_std_duplex: assert property (p_std_duplex) else $error("duplex not standard");
  property p_start_pulse;
    $rose(cable_test_start) |=> !cable_test_start [*2];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("launch not a pulse");
  property p_full_pulse;
    core_full_reset |=> !core_full_reset;
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("reset not cleared");
  property p_restart_pulse;
    core_restart |=> !core_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart stuck");
  property p_chan_sel;
    test_channel_en == 4'hF || $onehot(test_channel_en);
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("bad channel set");
  property p_pin_drive;
    irq_pd_pin_n_oe |-> !irq_pd_pin_n_out;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin driven high");
  property p_rsvd_high;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rsvd_high: assert property (p_rsvd_high) else $error("upper read data set");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  c_launch: cover property (cable_test_start);
  c_full: cover property (core_full_reset);
  c_restart: cover property (core_restart);
endmodule // pcc_regs_checker

bind pcc_regs pcc_regs_checker u_chk (.sys_clk(sys_clk), .srst(srst),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .local_an_enable(local_an_enable), .local_forced_100(local_forced_100),
  .partner_forced_100(partner_forced_100), .std_full_duplex(std_full_duplex),
  .irq_pd_pin_n_out(irq_pd_pin_n_out), .irq_pd_pin_n_oe(irq_pd_pin_n_oe),
  .link_full_duplex(link_full_duplex), .cable_test_start(cable_test_start),
  .core_full_reset(core_full_reset), .core_restart(core_restart),
  .test_channel_en(test_channel_en));
